//--- rtl/tss_pkg.sv
// constants shared by the trigger step sequencer and its submodules
package tss_pkg;
	localparam int DW        = 16;
	localparam int AW        = 8;
	localparam int NTRIG     = 32;
	localparam int STEP_W    = 8;
	localparam int STEP_DEPTH = 16;
	localparam int PC_W      = 4;

	// register offsets (word index on the plain register port)
	localparam logic [AW-1:0] OFF_CTRL     = 8'h00;
	localparam logic [AW-1:0] OFF_MASK_LO  = 8'h01;
	localparam logic [AW-1:0] OFF_MASK_HI  = 8'h02;
	localparam logic [AW-1:0] OFF_HOLD     = 8'h03;
	localparam logic [AW-1:0] OFF_LIM_BASE = 8'h04;
	localparam logic [AW-1:0] OFF_ADJ      = 8'h0A;
	localparam logic [AW-1:0] OFF_STATUS   = 8'h0B;
	localparam logic [AW-1:0] OFF_ADC_CH   = 8'h0C;
	localparam logic [AW-1:0] OFF_CNT0     = 8'h0D;
	localparam logic [AW-1:0] OFF_CNT1     = 8'h0E;
	localparam logic [AW-1:0] OFF_STEP_BASE = 8'h10;

	// control register bit positions
	localparam int CTRL_ON_BIT  = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam int CTRL_SWT_BIT = 2;

	// limit slots, also the add/copy target index
	localparam int NLIM   = 6;
	localparam int LIM_C0 = 0;
	localparam int LIM_C1 = 1;
	localparam int LIM_T0 = 2;
	localparam int LIM_T1 = 3;
	localparam int LIM_SD = 4;
	localparam int LIM_L0 = 5;

	localparam logic [DW-1:0] RST_REG16 = 16'h0000;

	// step command codes in the upper nibble of a step
	localparam logic [3:0] CMD_CTRL    = 4'h0;
	localparam logic [3:0] CMD_ADDCOPY = 4'h1;
	localparam logic [3:0] CMD_JMPC0   = 4'hA;
	localparam logic [3:0] CMD_JMPC1   = 4'hB;

	// control step options
	localparam logic [3:0] OPT_SD_OFF   = 4'h2;
	localparam logic [3:0] OPT_SD_ON    = 4'h6;
	localparam logic [3:0] OPT_WAIT_T0  = 4'h8;
	localparam logic [3:0] OPT_WAIT_T1  = 4'h9;
	localparam logic [3:0] OPT_WAIT_SWT = 4'hB;
	localparam logic [3:0] OPT_CH_CNT0  = 4'hC;
	localparam logic [3:0] OPT_CH_CNT1  = 4'hD;
	localparam logic [3:0] OPT_CH_L0    = 4'hE;
	localparam logic [3:0] OPT_BCAST    = 4'hF;

	// trigger output groups
	localparam int TRIG_PWM      = 16;
	localparam int TRIG_RSV_LO   = 20;
	localparam int TRIG_RSV_HI   = 29;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FETCH = 3'b001,
		ST_EXEC  = 3'b010,
		ST_WAIT_T = 3'b011,
		ST_WAIT_SWT = 3'b100,
		ST_WAIT_SD = 3'b101
	} tss_state_t;
endpackage : tss_pkg

//--- rtl/tss_sequencer.sv
// trigger step sequencer: register file, step fetch and execution
//
// The register offsets and the address-and-strobe port are this design's own decisions.
module tss_sequencer
	import tss_pkg::*;
#(
	parameter int DEPTH   = STEP_DEPTH,
	parameter bit HAS_PWM = 1'b1
)
(
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [AW-1:0]    reg_addr,
	input  wire logic [DW-1:0]    reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [DW-1:0]    reg_rdata,
	output logic      [DW-1:0]    adc_channel_select_reg,
	output logic                  adc_channel_wr,
	output logic      [NTRIG-1:0] trigger_output_line
);
	typedef struct packed {
		tss_state_t                    state;
		logic [PC_W-1:0]               pc;
		logic [STEP_W-1:0]             ir;
		logic                          on;
		logic                          run;
		logic                          swt;
		logic                          swt_prev;
		logic                          sd_en;
		logic [NTRIG-1:0]              mask;
		logic [DW-1:0]                 hold;
		logic [DW-1:0]                 adj;
		logic [NLIM-1:0][DW-1:0]       lim;
		logic [DW-1:0]                 cnt0;
		logic [DW-1:0]                 cnt1;
		logic [DEPTH-1:0][STEP_W-1:0]  steps;
		logic                          t0_go;
		logic                          t1_go;
		logic                          sd_go;
		logic                          wait_t1;
		logic                          fire;
		logic [DW-1:0]                 adc_ch;
		logic                          adc_wr;
		logic [DW-1:0]                 rdata;
	} tss_seq_t;

	tss_seq_t    st_ff;
	tss_seq_t    nxt_st;
	logic        t0_done;
	logic        t1_done;
	logic        sd_done;
	logic        locked;
	logic [3:0]  cmd;
	logic [3:0]  opt;
	logic [2:0]  slot;
	logic [AW-1:0] lim_idx;
	logic [AW-1:0] step_idx;
	logic        tmr_done;

	assign cmd      = st_ff.ir[7:4];
	assign opt      = st_ff.ir[3:0];
	assign slot     = opt[2:0];
	assign locked   = st_ff.on && st_ff.run;
	assign lim_idx  = reg_addr - OFF_LIM_BASE;
	assign step_idx = reg_addr - OFF_STEP_BASE;
	assign tmr_done = st_ff.wait_t1 ? t1_done : t0_done;

	tss_step_timer #(.W(DW)) u_tmr0 (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (st_ff.t0_go),
		.limit   (st_ff.lim[LIM_T0]),
		.done    (t0_done)
	);

	tss_step_timer #(.W(DW)) u_tmr1 (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (st_ff.t1_go),
		.limit   (st_ff.lim[LIM_T1]),
		.done    (t1_done)
	);

	tss_step_timer #(.W(DW)) u_sdly (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (st_ff.sd_go),
		.limit   (st_ff.lim[LIM_SD]),
		.done    (sd_done)
	);

	tss_trig_out #(.N(NTRIG), .HAS_PWM(HAS_PWM)) u_trig (
		.clk                 (clk),
		.sys_rst             (sys_rst),
		.fire                (st_ff.fire),
		.mask                (st_ff.mask),
		.trigger_output_line (trigger_output_line)
	);

	always_comb
	begin
		nxt_st        = st_ff;
		nxt_st.t0_go  = 1'b0;
		nxt_st.t1_go  = 1'b0;
		nxt_st.sd_go  = 1'b0;
		nxt_st.fire   = 1'b0;
		nxt_st.adc_wr = 1'b0;
		nxt_st.rdata  = '0;
		nxt_st.swt_prev = st_ff.swt;

		// register writes
		if (reg_wr)
		begin
			if (reg_addr == OFF_CTRL)
			begin
				nxt_st.on  = reg_wdata[CTRL_ON_BIT];
				nxt_st.run = reg_wdata[CTRL_RUN_BIT];
				nxt_st.swt = reg_wdata[CTRL_SWT_BIT];
			end
			else if (reg_addr == OFF_MASK_LO)
				nxt_st.mask[15:0] = reg_wdata;
			else if (reg_addr == OFF_MASK_HI)
				nxt_st.mask[31:16] = reg_wdata;
			else if (reg_addr == OFF_HOLD && !locked)
				nxt_st.hold = reg_wdata;
			else if (reg_addr >= OFF_LIM_BASE && lim_idx < NLIM && !locked)
				nxt_st.lim[lim_idx[2:0]] = reg_wdata;
			else if (reg_addr == OFF_ADJ)
				nxt_st.adj = reg_wdata;
			else if (reg_addr >= OFF_STEP_BASE && step_idx < DEPTH
				&& !locked)
				nxt_st.steps[step_idx[PC_W-1:0]] = reg_wdata[STEP_W-1:0];
		end

		// register reads, answered in the following cycle
		if (reg_rd)
		begin
			if (reg_addr == OFF_CTRL)
			begin
				nxt_st.rdata[CTRL_ON_BIT]  = st_ff.on;
				nxt_st.rdata[CTRL_RUN_BIT] = st_ff.run;
				nxt_st.rdata[CTRL_SWT_BIT] = st_ff.swt;
			end
			else if (reg_addr == OFF_MASK_LO)
				nxt_st.rdata = st_ff.mask[15:0];
			else if (reg_addr == OFF_MASK_HI)
				nxt_st.rdata = st_ff.mask[31:16];
			else if (reg_addr == OFF_HOLD)
				nxt_st.rdata = st_ff.hold;
			else if (reg_addr >= OFF_LIM_BASE && lim_idx < NLIM)
				nxt_st.rdata = st_ff.lim[lim_idx[2:0]];
			else if (reg_addr == OFF_ADJ)
				nxt_st.rdata = st_ff.adj;
			else if (reg_addr == OFF_STATUS)
				nxt_st.rdata = {7'h00, st_ff.sd_en, 1'b0, st_ff.state,
					st_ff.pc};
			else if (reg_addr == OFF_ADC_CH)
				nxt_st.rdata = st_ff.adc_ch;
			else if (reg_addr == OFF_CNT0)
				nxt_st.rdata = st_ff.cnt0;
			else if (reg_addr == OFF_CNT1)
				nxt_st.rdata = st_ff.cnt1;
			else if (reg_addr >= OFF_STEP_BASE && step_idx < DEPTH)
				nxt_st.rdata = {8'h00, st_ff.steps[step_idx[PC_W-1:0]]};
		end

		// step sequencer
		case (st_ff.state)
			ST_IDLE:
			begin
				if (locked)
					nxt_st.state = ST_FETCH;
			end
			ST_FETCH:
			begin
				nxt_st.ir    = st_ff.steps[st_ff.pc];
				nxt_st.pc    = st_ff.pc + 1'b1;
				nxt_st.state = ST_EXEC;
			end
			ST_EXEC:
			begin
				nxt_st.state = st_ff.sd_en ? ST_WAIT_SD : ST_FETCH;
				nxt_st.sd_go = st_ff.sd_en;
				case (cmd)
					CMD_CTRL:
					begin
						case (opt)
							OPT_SD_OFF:
							begin
								nxt_st.sd_en = 1'b0;
								nxt_st.sd_go = 1'b0;
								nxt_st.state = ST_FETCH;
							end
							OPT_SD_ON:
							begin
								nxt_st.sd_en = 1'b1;
								nxt_st.sd_go = 1'b1;
								nxt_st.state = ST_WAIT_SD;
							end
							OPT_WAIT_T0:
							begin
								nxt_st.t0_go   = 1'b1;
								nxt_st.wait_t1 = 1'b0;
								nxt_st.sd_go   = 1'b0;
								nxt_st.state   = ST_WAIT_T;
							end
							OPT_WAIT_T1:
							begin
								nxt_st.t1_go   = 1'b1;
								nxt_st.wait_t1 = 1'b1;
								nxt_st.sd_go   = 1'b0;
								nxt_st.state   = ST_WAIT_T;
							end
							OPT_WAIT_SWT:
							begin
								nxt_st.sd_go = 1'b0;
								nxt_st.state = ST_WAIT_SWT;
							end
							OPT_CH_CNT0:
							begin
								nxt_st.adc_ch = st_ff.cnt0;
								nxt_st.adc_wr = 1'b1;
							end
							OPT_CH_CNT1:
							begin
								nxt_st.adc_ch = st_ff.cnt1;
								nxt_st.adc_wr = 1'b1;
							end
							OPT_CH_L0:
							begin
								nxt_st.adc_ch = st_ff.lim[LIM_L0];
								nxt_st.adc_wr = 1'b1;
							end
							OPT_BCAST:
								nxt_st.fire = 1'b1;
							default:
								nxt_st.fire = 1'b0;
						endcase
					end
					CMD_ADDCOPY:
					begin
						// slots past literal zero are reserved targets
						if (slot < NLIM)
						begin
							if (opt[3])
								nxt_st.lim[slot] = st_ff.hold;
							else
								nxt_st.lim[slot] = st_ff.lim[slot]
									+ st_ff.adj;
						end
					end
					CMD_JMPC0:
					begin
						if (st_ff.cnt0 == st_ff.lim[LIM_C0])
							nxt_st.cnt0 = '0;
						else
						begin
							nxt_st.cnt0 = st_ff.cnt0 + 1'b1;
							nxt_st.pc   = opt;
						end
					end
					CMD_JMPC1:
					begin
						if (st_ff.cnt1 == st_ff.lim[LIM_C1])
							nxt_st.cnt1 = '0;
						else
						begin
							nxt_st.cnt1 = st_ff.cnt1 + 1'b1;
							nxt_st.pc   = opt;
						end
					end
					default:
						nxt_st.fire = 1'b0;
				endcase
			end
			ST_WAIT_T:
			begin
				// go pulse still in flight means the done flag is stale
				if (tmr_done && !st_ff.t0_go && !st_ff.t1_go)
				begin
					nxt_st.sd_go = st_ff.sd_en;
					nxt_st.state = st_ff.sd_en ? ST_WAIT_SD : ST_FETCH;
				end
			end
			ST_WAIT_SWT:
			begin
				if (st_ff.swt && !st_ff.swt_prev)
				begin
					nxt_st.sd_go = st_ff.sd_en;
					nxt_st.state = st_ff.sd_en ? ST_WAIT_SD : ST_FETCH;
				end
			end
			ST_WAIT_SD:
			begin
				// start pulse still in flight means the done flag is stale
				if (sd_done && !st_ff.sd_go)
					nxt_st.state = ST_FETCH;
			end
			default:
				nxt_st.state = ST_IDLE;
		endcase

		// stopping the module or the run bit halts and rewinds
		if (!locked)
		begin
			nxt_st.state = ST_IDLE;
			nxt_st.pc    = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign reg_rdata              = st_ff.rdata;
	assign adc_channel_select_reg = st_ff.adc_ch;
	assign adc_channel_wr         = st_ff.adc_wr;
endmodule : tss_sequencer

//--- rtl/tss_step_timer.sv
// up-counting timer that runs from zero until it meets its limit
module tss_step_timer
	import tss_pkg::*;
#(
	parameter int W = DW
)
(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         start,
	input  wire logic [W-1:0] limit,
	output logic              done
);
	typedef struct packed {
		logic         run;
		logic         done;
		logic [W-1:0] count;
	} tss_tmr_t;

	tss_tmr_t st_ff;
	tss_tmr_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		if (start)
		begin
			nxt_st.run   = 1'b1;
			nxt_st.done  = 1'b0;
			nxt_st.count = '0;
		end
		else if (st_ff.run)
		begin
			if (st_ff.count == limit)
			begin
				nxt_st.run  = 1'b0;
				nxt_st.done = 1'b1;
			end
			else
			begin
				nxt_st.count = st_ff.count + 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign done = st_ff.done;
endmodule : tss_step_timer

//--- rtl/tss_trig_out.sv
// registers one-cycle trigger pulses onto the trigger output lines
module tss_trig_out
	import tss_pkg::*;
#(
	parameter int N       = NTRIG,
	parameter bit HAS_PWM = 1'b1
)
(
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         fire,
	input  wire logic [N-1:0] mask,
	output logic [N-1:0]      trigger_output_line
);
	typedef struct packed {
		logic [N-1:0] trig;
	} tss_trg_t;

	tss_trg_t     st_ff;
	tss_trg_t     nxt_st;
	logic [N-1:0] allow;

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_allow
			// reserved lines never fire; pwm sync only on motor variants
			if (i >= TRIG_RSV_LO && i <= TRIG_RSV_HI)
				assign allow[i] = 1'b0;
			else if (i == TRIG_PWM)
				assign allow[i] = HAS_PWM;
			else
				assign allow[i] = 1'b1;
		end
	endgenerate

	always_comb
	begin
		nxt_st.trig = fire ? (mask & allow) : '0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign trigger_output_line = st_ff.trig;
endmodule : tss_trig_out

//--- tb/testbench.sv
// register-level tests of the trigger step sequencer
module testbench
	import tss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk;
	logic             sys_rst;
	logic [AW-1:0]    reg_addr;
	logic [DW-1:0]    reg_wdata;
	logic             reg_wr;
	logic             reg_rd;
	logic [DW-1:0]    reg_rdata;
	logic [DW-1:0]    adc_ch;
	logic             adc_wr;
	logic [NTRIG-1:0] trig;
	logic [7:0]       trig_cnt;
	logic [7:0]       ch_cnt;
	logic [NTRIG-1:0] last_trig;
	logic [DW-1:0]    last_ch;
	logic [7:0]       steps [$];
	int               miscompares;
	int               cmp_count;
	int               cycles;
	int               n;
	tss_sequencer uut (
		.clk                    (clk),
		.sys_rst                (sys_rst),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_rdata              (reg_rdata),
		.adc_channel_select_reg (adc_ch),
		.adc_channel_wr         (adc_wr),
		.trigger_output_line    (trig)
	);
	tss_far_model u_far (
		.clk                    (clk),
		.sys_rst                (sys_rst),
		.trigger_output_line    (trig),
		.adc_channel_select_reg (adc_ch),
		.adc_channel_wr         (adc_wr),
		.trig_cnt               (trig_cnt),
		.ch_cnt                 (ch_cnt),
		.last_trig              (last_trig),
		.last_ch                (last_ch)
	);
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			miscompares++;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input string what, input logic [AW-1:0] a,
		input logic [DW-1:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, reg_rdata, exp);
	endtask : rdc
	task automatic load();
		foreach (steps[i])
			wr(OFF_STEP_BASE + 8'(i), {8'h00, steps[i]});
	endtask : load
	// cycles until the far side sees the next trigger pulse
	task automatic wait_trig(output int k);
		logic [7:0] c0;
		c0 = trig_cnt;
		k = 0;
		while (trig_cnt === c0 && k < 200)
		begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask : wait_trig
	initial
	begin
		sys_rst = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		rdc("hold reset", OFF_HOLD, 16'h0000);
		rdc("c1lim reset", OFF_LIM_BASE + 8'h01, 16'h0000);
		wr(OFF_HOLD, 16'h0120);
		wr(OFF_ADJ, 16'h0003);
		wr(OFF_MASK_LO, 16'hFFFF);
		wr(OFF_MASK_HI, 16'hFFFF);
		steps = '{8'h1D, 8'h15, 8'h01, 8'hF5, 8'h0E, 8'h19, 8'h0B,
			8'h0F, 8'h0B};
		load();
		wr(OFF_CTRL, 16'h0003);
		repeat (30) @(posedge clk);
		#1;
		chk("adc channel", adc_ch, 32'h0123);
		chk("channel loads", ch_cnt, 32'h01);
		wr(OFF_HOLD, 16'h5555);
		#1;
		chk("stalled", trig_cnt, 32'h00);
		wr(OFF_CTRL, 16'h0007);
		wait_trig(n);
		chk("broadcast", last_trig, 32'hC00FFFFF);
		repeat (10) @(posedge clk);
		#1;
		chk("one broadcast", trig_cnt, 32'h01);
		wr(OFF_CTRL, 16'h0000);
		rdc("hold locked", OFF_HOLD, 16'h0120);
		rdc("c1lim copy", OFF_LIM_BASE + 8'h01, 16'h0120);
		rdc("literal add", OFF_LIM_BASE + 8'h05, 16'h0123);
		rdc("unmapped", 8'h0F, 16'h0000);
		$display("test program steps done");
		for (int i = 0; i < 2; i++)
		begin
			wr(OFF_LIM_BASE + 8'(LIM_T0), i ? 16'h0000 : 16'h0014);
			wr(OFF_LIM_BASE + 8'(LIM_T1), i ? 16'h0014 : 16'h0000);
			steps = '{8'(8'h08 + i), 8'h0F, 8'h0B};
			load();
			wr(OFF_CTRL, 16'h0003);
			wait_trig(n);
			chk("timer wait", n >= 20 && n < 40, 32'h1);
			wr(OFF_CTRL, 16'h0000);
		end
		$display("test timers done");
		wr(OFF_LIM_BASE + 8'(LIM_SD), 16'h000A);
		steps = '{8'h06, 8'h0F, 8'h0F, 8'h02, 8'h0F, 8'h0F, 8'h0B};
		load();
		wr(OFF_CTRL, 16'h0003);
		wait_trig(n);
		wait_trig(n);
		chk("delay gap", n >= 10, 32'h1);
		wait_trig(n);
		wait_trig(n);
		chk("no delay gap", n < 4, 32'h1);
		wr(OFF_CTRL, 16'h0000);
		$display("test step delay done");
		wr(OFF_LIM_BASE + 8'(LIM_C0), 16'h0001);
		wr(OFF_LIM_BASE + 8'(LIM_C1), 16'h0002);
		wr(OFF_MASK_LO, 16'h00F0);
		wr(OFF_MASK_HI, 16'h0000);
		steps = '{8'h0D, 8'h0F, 8'hB0, 8'h0C, 8'hA3, 8'h0B};
		load();
		wr(OFF_CTRL, 16'h0003);
		repeat (50) @(posedge clk);
		#1;
		chk("loop triggers", trig_cnt, 32'h0A);
		chk("loop loads", ch_cnt, 32'h06);
		chk("cnt0 channel", last_ch, 32'h0001);
		chk("masked lines", last_trig, 32'h000000F0);
		wr(OFF_LIM_BASE + 8'(LIM_C1), 16'h7777);
		wr(OFF_CTRL, 16'h0000);
		rdc("c1lim locked", OFF_LIM_BASE + 8'(LIM_C1), 16'h0002);
		rdc("cnt1 cleared", OFF_CNT1, 16'h0000);
		$display("test loops done");
		complete_run();
	end
endmodule : testbench

//--- tb/tss_far_model.sv
// far-side peripherals: count trigger pulses and channel loads
module tss_far_model
	import tss_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [NTRIG-1:0] trigger_output_line,
	input  wire logic [DW-1:0]    adc_channel_select_reg,
	input  wire logic             adc_channel_wr,
	output logic      [7:0]       trig_cnt,
	output logic      [7:0]       ch_cnt,
	output logic      [NTRIG-1:0] last_trig,
	output logic      [DW-1:0]    last_ch
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0]       tc;
		logic [7:0]       cc;
		logic [NTRIG-1:0] lt;
		logic [DW-1:0]    lc;
	} tss_far_t;
	tss_far_t st_ff;
	tss_far_t nxt_st;
	always_comb
	begin
		nxt_st = st_ff;
		if (|trigger_output_line)
		begin
			nxt_st.tc = st_ff.tc + 8'h01;
			nxt_st.lt = trigger_output_line;
		end
		if (adc_channel_wr)
		begin
			nxt_st.cc = st_ff.cc + 8'h01;
			nxt_st.lc = adc_channel_select_reg;
		end
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	assign trig_cnt = st_ff.tc;
	assign ch_cnt = st_ff.cc;
	assign last_trig = st_ff.lt;
	assign last_ch = st_ff.lc;
endmodule : tss_far_model

//--- tb/tss_seq_assertions.sv
// checker for the trigger step sequencer top-level ports
module tss_seq_assertions
	import tss_pkg::*;
#(
	parameter int DEPTH   = STEP_DEPTH,
	parameter bit HAS_PWM = 1'b1
)
(
	input wire logic             clk,
	input wire logic             sys_rst,
	input wire logic [AW-1:0]    reg_addr,
	input wire logic [DW-1:0]    reg_wdata,
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [DW-1:0]    reg_rdata,
	input wire logic [DW-1:0]    adc_channel_select_reg,
	input wire logic             adc_channel_wr,
	input wire logic [NTRIG-1:0] trigger_output_line
);
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [2:0]       ctrl;
		logic [DW-1:0]    hold;
		logic [NTRIG-1:0] mask;
	} tss_chk_t;
	tss_chk_t         st_ff;
	tss_chk_t         nxt_st;
	logic             run;
	logic [NTRIG-1:0] ok_lines;
	assign run = st_ff.ctrl[CTRL_ON_BIT] & st_ff.ctrl[CTRL_RUN_BIT];
	// shadow of control bits and of the hold value software may write
	always_comb
	begin
		nxt_st = st_ff;
		if (reg_wr && reg_addr == OFF_CTRL)
			nxt_st.ctrl = reg_wdata[2:0];
		if (reg_wr && reg_addr == OFF_HOLD && !run)
			nxt_st.hold = reg_wdata;
		if (reg_wr && reg_addr == OFF_MASK_LO)
			nxt_st.mask[15:0] = reg_wdata;
		if (reg_wr && reg_addr == OFF_MASK_HI)
			nxt_st.mask[31:16] = reg_wdata;
	end
	// lines that may fire: reserved never, pwm sync only with pwm
	always_comb
	begin
		ok_lines                          = '1;
		ok_lines[TRIG_RSV_HI:TRIG_RSV_LO] = '0;
		ok_lines[TRIG_PWM]                = HAS_PWM;
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	a_rdata_idle_zero: assert property (
		!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data not zero outside read cycle");
	a_hold_readback: assert property (
		reg_rd && reg_addr == OFF_HOLD |=> reg_rdata == st_ff.hold)
		else $error("hold value read back wrong");
	a_reset_quiet: assert property (
		$fell(sys_rst) |-> trigger_output_line == '0 && !adc_channel_wr)
		else $error("outputs active right after reset");
	a_trig_pulse: assert property (
		|trigger_output_line |=> trigger_output_line == '0)
		else $error("trigger held longer than one cycle");
	a_adc_wr_pulse: assert property (
		adc_channel_wr |=> !adc_channel_wr)
		else $error("channel load strobe too long");
	a_channel_stable: assert property (
		!adc_channel_wr |-> $stable(adc_channel_select_reg))
		else $error("channel value changed without load");
	a_reserved_quiet: assert property (
		trigger_output_line[TRIG_RSV_HI:TRIG_RSV_LO] == '0)
		else $error("reserved trigger line pulsed");
	a_pwm_line: assert property (
		trigger_output_line[TRIG_PWM] |-> HAS_PWM)
		else $error("pwm line pulsed on variant without pwm");
	a_trig_mask: assert property (
		|trigger_output_line |->
		trigger_output_line == ($past(st_ff.mask) & ok_lines))
		else $error("trigger lines differ from broadcast mask");
	a_trig_needs_run: assert property (
		|trigger_output_line |-> run || $past(run) || $past(run, 2)
		|| $past(run, 3))
		else $error("trigger while sequence stopped");
	a_adc_needs_run: assert property (
		adc_channel_wr |-> run || $past(run) || $past(run, 2))
		else $error("channel load while sequence stopped");
	c_bcast: cover property (|trigger_output_line);
	c_adc: cover property (adc_channel_wr);
	c_lock: cover property (run && reg_wr && reg_addr == OFF_HOLD);
endmodule : tss_seq_assertions

bind tss_sequencer tss_seq_assertions #(
	.DEPTH   (DEPTH),
	.HAS_PWM (HAS_PWM)
) u_chk (
	.clk                    (clk),
	.sys_rst                (sys_rst),
	.reg_addr               (reg_addr),
	.reg_wdata              (reg_wdata),
	.reg_wr                 (reg_wr),
	.reg_rd                 (reg_rd),
	.reg_rdata              (reg_rdata),
	.adc_channel_select_reg (adc_channel_select_reg),
	.adc_channel_wr         (adc_channel_wr),
	.trigger_output_line    (trigger_output_line)
);
